// >>> uhie_consts.svh
`ifndef UHIE_CONSTS_SVH
`define UHIE_CONSTS_SVH

// ==========================================================================
// host port command codes
`define UHIE_CMD_FLAGS_RD   8'h03
`define UHIE_CMD_FLAGS_WR   8'h83
`define UHIE_CMD_ENAB_RD    8'h04
`define UHIE_CMD_ENAB_WR    8'h84

// ==========================================================================
// bit positions in the flag and enable words and in frame_number
`define UHIE_BIT_SO           0
`define UHIE_BIT_FRAME_START  2
`define UHIE_BIT_RD           3
`define UHIE_BIT_UNRECOV_ERR  4
`define UHIE_BIT_FRAME_OVF    5
`define UHIE_BIT_ROOT_HUB_CHG 6
`define UHIE_BIT_MASTER_GATE  31
`define UHIE_BIT_FN_MSB       15

// ==========================================================================
// masks, reset values and the default port count
`define UHIE_EVENT_MASK     32'h0000007D
`define UHIE_ENAB_MASK      32'h8000007D
`define UHIE_FLAGS_RST      32'h00000000
`define UHIE_ENAB_RST       32'h00000000
`define UHIE_SOC_RST        2'h0
`define UHIE_PORT_COUNT     2

`endif

// >>> uhie_pkg.sv
package uhie_pkg;

  // state of the register core
  typedef struct packed {
    logic [31:0] flags;
    logic [31:0] enables;
    logic [1:0]  so_count;
    logic        irq;
    logic        halt;
    logic        sof_req;
  } uhie_core_t;

  // state of the command port
  typedef struct packed {
    logic [31:0] rd_data;
    logic        rd_valid;
  } uhie_cmd_t;

endpackage

// >>> uhie_event_detect.sv
`timescale 1ns/1ns
`include "uhie_consts.svh"

module uhie_event_detect #(
  parameter int PORT_COUNT = `UHIE_PORT_COUNT
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic [31:0]              root_hub_status,
  input  wire logic [PORT_COUNT*32-1:0] port_status,
  input  wire logic [15:0]              frame_number,
  input  wire logic                     resume_signaling,
  input  wire logic                     bus_resume_state,
  input  wire logic                     sys_error,
  input  wire logic                     frame_start,
  input  wire logic                     sched_overrun,
  output logic      [31:0]              events
);

  generate
    if (PORT_COUNT < 1 || PORT_COUNT > 15) begin : g_bad
      $error("uhie_event_detect: PORT_COUNT out of range");
    end
  endgenerate

  typedef struct packed {
    logic                     primed;
    logic [31:0]              rh_prev;
    logic [PORT_COUNT*32-1:0] port_prev;
    logic                     fn_msb_prev;
    logic                     resume_prev;
    logic [31:0]              events;
  } uhie_det_t;

  uhie_det_t s_r;
  uhie_det_t s_nxt;

  // ========================================================================
  // change detection for hub and frame bits, rising edge of resume outside bus resume; error, sof and overrun inputs registered as they come
  always_comb begin
    s_nxt             = s_r;
    s_nxt.primed      = 1'b1;
    s_nxt.rh_prev     = root_hub_status;
    s_nxt.port_prev   = port_status;
    s_nxt.fn_msb_prev = frame_number[`UHIE_BIT_FN_MSB];
    s_nxt.resume_prev = resume_signaling;
    s_nxt.events      = 32'h00000000;
    // no change seen before the first sample after reset
    s_nxt.events[`UHIE_BIT_ROOT_HUB_CHG] = s_r.primed &&
      (root_hub_status != s_r.rh_prev || port_status != s_r.port_prev);
    s_nxt.events[`UHIE_BIT_FRAME_OVF] = s_r.primed &&
      (frame_number[`UHIE_BIT_FN_MSB] != s_r.fn_msb_prev);
    s_nxt.events[`UHIE_BIT_UNRECOV_ERR] = sys_error;
    s_nxt.events[`UHIE_BIT_RD] = s_r.primed && resume_signaling &&
      !s_r.resume_prev && !bus_resume_state;
    s_nxt.events[`UHIE_BIT_FRAME_START] = frame_start;
    s_nxt.events[`UHIE_BIT_SO] = sched_overrun;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign events = s_r.events;

endmodule

// >>> uhie_cmd_port.sv
`timescale 1ns/1ns
`include "uhie_consts.svh"

module uhie_cmd_port (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [31:0] cmd_wdata,
  input  wire logic [31:0] flags,
  input  wire logic [31:0] enables,
  output logic      [31:0] flags_clr,
  output logic      [31:0] enab_set,
  output logic      [31:0] rd_data,
  output logic             rd_valid
);

  uhie_pkg::uhie_cmd_t s_r;
  uhie_pkg::uhie_cmd_t s_nxt;

  // ========================================================================
  // write decode
  always_comb begin
    flags_clr = 32'h00000000;
    enab_set  = 32'h00000000;
    if (cmd_valid && cmd_code == `UHIE_CMD_FLAGS_WR) begin
      flags_clr = cmd_wdata;
    end
    if (cmd_valid && cmd_code == `UHIE_CMD_ENAB_WR) begin
      enab_set = cmd_wdata;
    end
  end

  // ========================================================================
  // read answer, one cycle after the command; unknown codes get none
  always_comb begin
    s_nxt          = s_r;
    s_nxt.rd_valid = 1'b0;
    if (cmd_valid && cmd_code == `UHIE_CMD_FLAGS_RD) begin
      s_nxt.rd_valid = 1'b1;
      s_nxt.rd_data  = flags;
    end else if (cmd_valid && cmd_code == `UHIE_CMD_ENAB_RD) begin
      s_nxt.rd_valid = 1'b1;
      s_nxt.rd_data  = enables;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign rd_data  = s_r.rd_data;
  assign rd_valid = s_r.rd_valid;

endmodule

// >>> uhie_top.sv
`timescale 1ns/1ns
`include "uhie_consts.svh"

module uhie_top #(
  parameter int PORT_COUNT = `UHIE_PORT_COUNT
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     cmd_valid,
  input  wire logic [7:0]               cmd_code,
  input  wire logic [31:0]              cmd_wdata,
  output logic      [31:0]              rd_data,
  output logic                          rd_valid,
  input  wire logic [31:0]              root_hub_status,
  input  wire logic [PORT_COUNT*32-1:0] port_status,
  input  wire logic [15:0]              frame_number,
  input  wire logic                     resume_signaling,
  input  wire logic                     bus_resume_state,
  input  wire logic                     sys_error,
  input  wire logic                     frame_start,
  input  wire logic                     sched_overrun,
  output logic                          irq,
  output logic                          halt_processing,
  output logic                          sof_token_req,
  output logic      [1:0]               sched_overrun_count
);

  uhie_pkg::uhie_core_t s_r;
  uhie_pkg::uhie_core_t s_nxt;

  logic [31:0] events;
  logic [31:0] flags_clr;
  logic [31:0] enab_set;

  // ========================================================================
  // event capture
  uhie_event_detect #(
    .PORT_COUNT (PORT_COUNT)
  ) u_detect (
    .clk              (clk),
    .rst              (rst),
    .root_hub_status  (root_hub_status),
    .port_status      (port_status),
    .frame_number     (frame_number),
    .resume_signaling (resume_signaling),
    .bus_resume_state (bus_resume_state),
    .sys_error        (sys_error),
    .frame_start      (frame_start),
    .sched_overrun    (sched_overrun),
    .events           (events)
  );

  // ========================================================================
  // host command port
  uhie_cmd_port u_cmd (
    .clk       (clk),
    .rst       (rst),
    .cmd_valid (cmd_valid),
    .cmd_code  (cmd_code),
    .cmd_wdata (cmd_wdata),
    .flags     (s_r.flags),
    .enables   (s_r.enables),
    .flags_clr (flags_clr),
    .enab_set  (enab_set),
    .rd_data   (rd_data),
    .rd_valid  (rd_valid)
  );

  // ========================================================================
  // any enabled pending flag under master enable
  function automatic logic irq_pending(input logic [31:0] f, input logic [31:0] e);
    irq_pending = e[`UHIE_BIT_MASTER_GATE] && |(f & e & `UHIE_EVENT_MASK);
  endfunction

  // ========================================================================
  // register core
  always_comb begin
    s_nxt = s_r;
    // set wins over a clear in the same cycle
    s_nxt.flags = ((s_r.flags & ~flags_clr) | events) & `UHIE_EVENT_MASK;
    // enables only ever get set, a written 0 is ignored
    s_nxt.enables = (s_r.enables | enab_set) & `UHIE_ENAB_MASK;
    if (events[`UHIE_BIT_SO]) begin
      s_nxt.so_count = s_r.so_count + 2'h1;
    end
    // held until software clears the flag or reset clears it
    s_nxt.halt    = s_nxt.flags[`UHIE_BIT_UNRECOV_ERR];
    s_nxt.sof_req = events[`UHIE_BIT_FRAME_START];
    s_nxt.irq     = irq_pending(s_nxt.flags, s_nxt.enables);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_r.flags    <= `UHIE_FLAGS_RST;
      s_r.enables  <= `UHIE_ENAB_RST;
      s_r.so_count <= `UHIE_SOC_RST;
      s_r.irq      <= 1'b0;
      s_r.halt     <= 1'b0;
      s_r.sof_req  <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign irq                 = s_r.irq;
  assign halt_processing     = s_r.halt;
  assign sof_token_req       = s_r.sof_req;
  assign sched_overrun_count = s_r.so_count;

endmodule

// >>> uhie_checker.sv
`timescale 1ns/1ns
// ==========================
// port checker
module uhie_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wire logic [7:0]  cmd_code,
  input wire logic [31:0] cmd_wdata,
  input wire logic        rd_valid,
  input wire logic        sys_error,
  input wire logic        frame_start,
  input wire logic        sched_overrun,
  input wire logic        irq,
  input wire logic        halt_processing,
  input wire logic        sof_token_req,
  input wire logic [1:0]  sched_overrun_count
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire logic rd_cmd;
  wire logic flag_wr;
  assign rd_cmd  = cmd_valid && (cmd_code == 8'h03 || cmd_code == 8'h04);
  assign flag_wr = cmd_valid && cmd_code == 8'h83;
  a_read_answer: assert property (rd_cmd |=> rd_valid)
    else $error("read got no answer");
  a_no_stray_read: assert property (!rd_cmd |=> !rd_valid)
    else $error("answer without read");
  a_sof_token: assert property (frame_start |-> ##2 sof_token_req)
    else $error("no sof token request");
  a_count_step: assert property (sched_overrun |-> ##2
    sched_overrun_count == $past(sched_overrun_count) + 2'h1) else $error("count not stepped");
  a_count_hold: assert property (!sched_overrun |-> ##2 $stable(sched_overrun_count))
    else $error("count moved alone");
  a_halt_set: assert property (sys_error |-> ##2 halt_processing)
    else $error("no halt on error");
  a_halt_keep: assert property (halt_processing && !(flag_wr && cmd_wdata[4]) |=>
    halt_processing) else $error("halt dropped alone");
  a_irq_keep: assert property (irq && !flag_wr |=> irq)
    else $error("irq dropped alone");
  c_irq: cover property ($rose(irq));
  c_wrap: cover property (sched_overrun_count == 2'h3 ##1 sched_overrun_count == 2'h0);
  c_halt: cover property ($rose(halt_processing));
endmodule

bind uhie_top uhie_checker u_uhie_checker (.clk, .rst, .cmd_valid, .cmd_code, .cmd_wdata,
  .rd_valid, .sys_error, .frame_start, .sched_overrun, .irq, .halt_processing,
  .sof_token_req, .sched_overrun_count);

// >>> uhie_host_model.sv
`timescale 1ns/1ns
// ==========================
// host driver side of the command port
module uhie_host_model (
  input  wire logic        clk,
  output logic             cmd_valid,
  output logic [7:0]       cmd_code,
  output logic [31:0]      cmd_wdata,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_valid
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = 8'hFF;
    cmd_wdata = 32'h0;
  end
  // answer sampled in the cycle after the taking edge
  task automatic xfer(input logic [7:0] code, input logic [31:0] wd,
                      output logic [31:0] rd, output logic ok);
    @(posedge clk) #5;
    cmd_valid = 1'b1;
    cmd_code  = code;
    cmd_wdata = wd;
    @(posedge clk) #5;
    ok        = rd_valid;
    rd        = rd_data;
    cmd_valid = 1'b0;
    cmd_code  = ~code;
    cmd_wdata = ~wd;
  endtask
endmodule

// >>> usb_host_irq_status_enable_bench.sv
`timescale 1ns/1ns
// ==========================
// bench
module usb_host_irq_status_enable_bench;
  logic        clk, rst, cmd_valid, rd_valid, resume_signaling, bus_resume_state;
  logic        sys_error, frame_start, sched_overrun, irq, halt_processing, sof_token_req;
  logic [7:0]  cmd_code;
  logic [31:0] cmd_wdata, rd_data, root_hub_status;
  logic [63:0] port_status;
  logic [15:0] frame_number;
  logic [1:0]  sched_overrun_count;
  int          num_errors, samples_checked, cycles;
  int          sof_seen;

  // sof requests as sampled at clock edges
  always @(posedge clk) begin
    if (sof_token_req === 1'b1) begin
      sof_seen++;
    end
  end

  uhie_top #(.PORT_COUNT(2)) u_uhie_top (.clk, .rst, .cmd_valid, .cmd_code, .cmd_wdata,
    .rd_data, .rd_valid, .root_hub_status, .port_status, .frame_number, .resume_signaling,
    .bus_resume_state, .sys_error, .frame_start, .sched_overrun, .irq, .halt_processing,
    .sof_token_req, .sched_overrun_count);
  uhie_host_model u_uhie_host_model (.clk, .cmd_valid, .cmd_code, .cmd_wdata, .rd_data,
    .rd_valid);

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic rd_reg(input logic [7:0] code, input logic [31:0] exp);
    logic [31:0] d;
    logic        ok;
    u_uhie_host_model.xfer(code, 32'h0, d, ok);
    chk_bit(ok, 1'b1);
    chk_word(d, exp);
  endtask
  task automatic wr_reg(input logic [7:0] code, input logic [31:0] wd);
    logic [31:0] d;
    logic        ok;
    u_uhie_host_model.xfer(code, wd, d, ok);
    chk_bit(ok, 1'b0);
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk) #5 s = 1'b1;
    @(posedge clk) #5 s = 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  initial begin
    {rst, resume_signaling, bus_resume_state, sys_error, frame_start, sched_overrun} = 6'h20;
    root_hub_status = 32'h0;
    port_status = 64'h0;
    frame_number = 16'h0;
    repeat (4) @(posedge clk);
    #5 rst = 1'b0;
    rd_reg(8'h03, 32'h0);
    rd_reg(8'h04, 32'h0);
    wr_reg(8'h00, 32'hFFFFFFFF);
    wr_reg(8'h84, 32'h00000004);
    pulse(frame_start);
    rd_reg(8'h03, 32'h00000004);
    chk_word(sof_seen, 32'h1);
    chk_bit(irq, 1'b0);
    wr_reg(8'h84, 32'h80000000);
    rd_reg(8'h04, 32'h80000004);
    chk_bit(irq, 1'b1);
    wr_reg(8'h84, 32'h0);
    rd_reg(8'h04, 32'h80000004);
    wr_reg(8'h83, 32'hFFFFFF83);
    rd_reg(8'h03, 32'h00000004);
    wr_reg(8'h83, 32'h00000004);
    chk_bit(irq, 1'b0);
    $display("gating test done");
    wr_reg(8'h84, 32'hFFFFFFFF);
    rd_reg(8'h04, 32'h8000007D);
    repeat (5) pulse(sched_overrun);
    chk_word({30'h0, sched_overrun_count}, 32'h1);
    #5 frame_number = 16'h8000;
    repeat (3) @(posedge clk);
    rd_reg(8'h03, 32'h00000021);
    @(posedge clk) #5 port_status[63:32] = 32'h1;
    bus_resume_state = 1'b1;
    resume_signaling = 1'b1;
    repeat (3) @(posedge clk);
    rd_reg(8'h03, 32'h00000061);
    @(posedge clk) #5 resume_signaling = 1'b0;
    bus_resume_state = 1'b0;
    root_hub_status = 32'h1;
    repeat (3) @(posedge clk);
    #5 resume_signaling = 1'b1;
    repeat (3) @(posedge clk);
    wr_reg(8'h83, 32'h00000020);
    @(posedge clk) #5 frame_number = 16'h0;
    repeat (3) @(posedge clk);
    rd_reg(8'h03, 32'h00000069);
    $display("event test done");
    pulse(sys_error);
    chk_bit(halt_processing, 1'b1);
    wr_reg(8'h83, 32'h0000006D);
    rd_reg(8'h03, 32'h00000010);
    chk_bit(irq, 1'b1);
    @(posedge clk) #5 rst = 1'b1;
    @(posedge clk) #5 rst = 1'b0;
    wr_reg(8'h83, 32'h00000010);
    rd_reg(8'h03, 32'h0);
    chk_bit(halt_processing, 1'b0);
    chk_word(sof_seen, 32'h1);
    $display("error test done");
    tally_and_finish();
  end
endmodule
